// ---- hdl/wsc_wait_state_controller.sv ----
// Wait-state controller that times the ready answer for processor bus cycles.
// Functional notes
// [RQ1] Each handled bus cycle gets its ready answer only once its wait states have run out.
// [RQ2] Cycles addressed to the math coprocessor get no ready answer from this block.
// [RQ3] The coprocessor itself must end its own cycles with its own ready signal.
// [RQ4] Memory reads that hit the cache are left alone and finish with zero wait states.
// [RQ5] A pipelined cache miss that hits the open page gets exactly one wait state.
// [RQ6] Local I/O gets 3, 3, 5 or 7 wait states by frequency, one more after a non-pipelined cycle.
// [RQ7] Channel cycles, interrupt acknowledge included, end only on the channel ready return.
// [RQ8] Halt and shutdown cycles are answered with zero wait states.
// [RQ9] A write to the coprocessor reset port gets 130 wait states instead of the I/O timing.
// [RQ10] While the test input is low, the ready and bus-size pin outputs are released to high impedance.
// [RQ11] The channel ready and data-size returns are synchronised before any logic uses them.
// [RQ12] The two frequency straps are caught once after reset and pick the wait counts.
// [RQ13] The counter loads at each cycle start from kind and frequency and counts clock phases.
`include "wsc_params.svh"

module wsc_wait_state_controller
  import wsc_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // Clock and reset; the clock is the double-frequency processor clock.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Bus cycle announcement from the local bus decoder on the same clock.
  input  wire logic          cycle_start_i,
  input  wire wsc_cycle_type cycle_i,
  // Asynchronous returns from the expansion channel.
  input  wire logic          channel_ready_return_n_i,
  input  wire logic          size16_return_n_i,
  input  wire logic          size32_return_n_i,
  // Asynchronous frequency straps and test pin.
  input  wire logic          freq_strap_hi_i,
  input  wire logic          freq_strap_lo_i,
  input  wire logic          test_n_i,
  // Ready answer to the processor.
  output logic               sys_ready_out_n_o,
  output logic               sys_ready_oe_o,
  // Bus size answers to the processor.
  output logic               bus_size16_n_o,
  output logic               bus_size16_oe_o,
  // Status for the surrounding logic.
  output logic               cycle_busy_o,
  output wsc_freq_type       freq_sel_o
);

  // Controller states for one bus cycle.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COUNT,
    ST_CHANNEL,
    ST_READY
  } wsc_state_type;

  wsc_state_type        state_reg;
  logic [CNT_W-1:0]     count_reg;
  wsc_freq_type         freq_reg;
  logic                 strap_taken_reg;
  logic [1:0]           strap_age_reg;
  logic                 ready_n_reg;
  logic                 size16_n_reg;
  logic [1:0]           chrdy_sync_reg;
  logic [1:0]           size16_sync_reg;
  logic [1:0]           size32_sync_reg;
  logic [1:0]           test_sync_reg;
  logic [1:0]           strap_hi_sync_reg;
  logic [1:0]           strap_lo_sync_reg;
  logic                 chrdy_n;
  logic                 size16_n;
  logic                 size32_n;
  logic                 test_n;
  logic                 coproc_reset_write;
  logic [CNT_W-1:0]     load_count;

  // Map the strap pair onto a frequency.
  function automatic wsc_freq_type strap_to_freq(input logic [1:0] straps);
    wsc_freq_type f;
    f = WSC_FREQ_16;
    unique case (straps)
      `WSC_STRAP_16MHZ: f = WSC_FREQ_16;
      `WSC_STRAP_20MHZ: f = WSC_FREQ_20;
      `WSC_STRAP_25MHZ: f = WSC_FREQ_25;
      `WSC_STRAP_33MHZ: f = WSC_FREQ_33;
    endcase
    return f;
  endfunction : strap_to_freq

  // Local I/O wait states for a frequency and the previous cycle's pipelining.
  function automatic logic [8:0] io_wait_states(input wsc_freq_type f, input logic piped);
    logic [8:0] ws;
    ws = `WSC_IO_WS_PIPE_16;
    unique case (f)
      WSC_FREQ_16: ws = `WSC_IO_WS_PIPE_16;
      WSC_FREQ_20: ws = `WSC_IO_WS_PIPE_20;
      WSC_FREQ_25: ws = `WSC_IO_WS_PIPE_25;
      WSC_FREQ_33: ws = `WSC_IO_WS_PIPE_33;
    endcase
    if (!piped) begin
      ws = ws + `WSC_IO_WS_NONPIPE_EXTRA; // [RQ6]
    end
    return ws;
  endfunction : io_wait_states

  // Convert wait states into clock phases; the counter runs on every phase.
  function automatic logic [CNT_W-1:0] ws_to_phases(input logic [8:0] ws);
    logic [CNT_W-1:0] wide;
    wide = CNT_W'({1'b0, ws}) * CNT_W'(`WSC_PHASES_PER_WS);
    return wide;
  endfunction : ws_to_phases

  // True in the last counted phase, the one in which ready must be launched.
  // The sequencer and the ready flop share it so that they can never drift apart.
  function automatic logic last_phase(input logic [CNT_W-1:0] cnt);
    return cnt <= CNT_W'(1);
  endfunction : last_phase

  // Two-flop synchronisers for every pin that is not on this clock.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chrdy_sync_reg    <= 2'h3;
      size16_sync_reg   <= 2'h3;
      size32_sync_reg   <= 2'h3;
      test_sync_reg     <= 2'h3;
      strap_hi_sync_reg <= 2'h0;
      strap_lo_sync_reg <= 2'h0;
    end else begin
      chrdy_sync_reg    <= {chrdy_sync_reg[0], channel_ready_return_n_i};   // [RQ11]
      size16_sync_reg   <= {size16_sync_reg[0], size16_return_n_i};         // [RQ11]
      size32_sync_reg   <= {size32_sync_reg[0], size32_return_n_i};         // [RQ11]
      test_sync_reg     <= {test_sync_reg[0], test_n_i};
      strap_hi_sync_reg <= {strap_hi_sync_reg[0], freq_strap_hi_i};
      strap_lo_sync_reg <= {strap_lo_sync_reg[0], freq_strap_lo_i};
    end
  end

  // Only the second flop of each synchroniser is read by logic.
  assign chrdy_n  = chrdy_sync_reg[1];
  assign size16_n = size16_sync_reg[1];
  assign size32_n = size32_sync_reg[1];
  assign test_n   = test_sync_reg[1];

  // Catch the straps once, after the synchronisers have filled following reset.
  // The second flop still holds its reset value for two edges, so the capture
  // waits for the third edge; a bus cycle started earlier would see 16 MHz counts.
  // A strap change later on is ignored, since the wait counts must not move mid-run.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      freq_reg        <= WSC_FREQ_16;
      strap_taken_reg <= 1'b0;
      strap_age_reg   <= 2'h0;
    end else if (!strap_taken_reg) begin
      if (strap_age_reg == 2'h2) begin
        freq_reg        <= strap_to_freq({strap_hi_sync_reg[1], strap_lo_sync_reg[1]}); // [RQ12]
        strap_taken_reg <= 1'b1;
      end else begin
        strap_age_reg <= strap_age_reg + 2'h1;
      end
    end
  end

  // A write to the coprocessor reset port overrides the local I/O timing.
  assign coproc_reset_write = (cycle_i.kind == WSC_CYC_LOCAL_IO) && cycle_i.write &&
                              (cycle_i.io_addr == `WSC_COPROC_RESET_PORT); // [RQ9]

  // Phase count loaded at the start of a counted cycle.
  always_comb begin
    load_count = '0;
    if (coproc_reset_write) begin
      load_count = ws_to_phases(`WSC_COPROC_RESET_WS);                          // [RQ9]
    end else if (cycle_i.kind == WSC_CYC_LOCAL_IO) begin
      load_count = ws_to_phases(io_wait_states(freq_reg, cycle_i.after_pipelined)); // [RQ6]
    end else if (cycle_i.kind == WSC_CYC_PAGE_HIT) begin
      load_count = ws_to_phases(`WSC_PAGE_HIT_WS);                              // [RQ5]
    end
  end

  // Cycle sequencer: decide at the start how the cycle ends, then end it.
  // Starts are ignored while a cycle is in progress; the processor cannot start
  // another before the ready answer of the current one.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cycle_start_i) begin
            unique case (cycle_i.kind)
              WSC_CYC_CACHE_HIT: state_reg <= ST_IDLE;  // [RQ4]
              WSC_CYC_COPROC:    state_reg <= ST_IDLE;  // [RQ2] [RQ3]
              WSC_CYC_HALT:      state_reg <= ST_READY; // [RQ8]
              WSC_CYC_CHANNEL:   state_reg <= ST_CHANNEL; // [RQ7]
              WSC_CYC_PAGE_HIT:  state_reg <= ST_COUNT; // [RQ13]
              WSC_CYC_LOCAL_IO:  state_reg <= ST_COUNT; // [RQ13]
              default:           state_reg <= ST_IDLE;
            endcase
          end
        end
        ST_COUNT: begin
          if (last_phase(count_reg)) begin
            state_reg <= ST_READY; // [RQ1]
          end
        end
        ST_CHANNEL: begin
          if (!chrdy_n) begin
            state_reg <= ST_READY; // [RQ7]
          end
        end
        ST_READY: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Wait-state counter, one step per double-frequency clock phase.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (state_reg == ST_IDLE && cycle_start_i) begin
      count_reg <= load_count; // [RQ13]
    end else if (state_reg == ST_COUNT && count_reg != '0) begin
      count_reg <= count_reg - CNT_W'(1); // [RQ13]
    end
  end

  // Ready is a registered low pulse lasting one phase, in the last phase of the cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_n_reg <= 1'b1;
    end else begin
      ready_n_reg <= !((state_reg == ST_IDLE && cycle_start_i &&
                        cycle_i.kind == WSC_CYC_HALT) ||
                       (state_reg == ST_COUNT && last_phase(count_reg)) ||
                       (state_reg == ST_CHANNEL && !chrdy_n)); // [RQ1] [RQ8]
    end
  end

  // Bus size to the processor follows the synchronised channel returns.
  // A 32-bit return wins, since the port is then at least as wide as a word.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      size16_n_reg <= 1'b1;
    end else begin
      size16_n_reg <= !(state_reg == ST_CHANNEL && !size16_n && size32_n); // [RQ11]
    end
  end

  // Pin drivers; the test input releases the ready and bus-size pins.
  // The ready pin is shared with the coprocessor, so it is driven only while
  // a cycle of ours runs, never on a coprocessor cycle.
  assign sys_ready_out_n_o = ready_n_reg;
  assign sys_ready_oe_o    = test_n && (state_reg != ST_IDLE || !ready_n_reg); // [RQ2] [RQ10]
  assign bus_size16_n_o    = size16_n_reg;
  assign bus_size16_oe_o   = test_n;                                          // [RQ10]
  assign cycle_busy_o      = state_reg != ST_IDLE;
  assign freq_sel_o        = freq_reg;

endmodule : wsc_wait_state_controller

// ---- pkg/wsc_params.svh ----
// Constants for the wait-state controller: strap codes, wait counts and timing figures.
`ifndef WSC_PARAMS_SVH
`define WSC_PARAMS_SVH

// Frequency strap codes, high strap first.
`define WSC_STRAP_16MHZ 2'h0
`define WSC_STRAP_20MHZ 2'h1
`define WSC_STRAP_25MHZ 2'h3
`define WSC_STRAP_33MHZ 2'h2

// Local I/O access time in nanoseconds.
`define WSC_IO_ACCESS_NS 100

// Local I/O wait states after a pipelined cycle, per frequency.
`define WSC_IO_WS_PIPE_16 9'h003
`define WSC_IO_WS_PIPE_20 9'h003
`define WSC_IO_WS_PIPE_25 9'h005
`define WSC_IO_WS_PIPE_33 9'h007

// Extra wait state that a cycle after a non-pipelined cycle needs.
`define WSC_IO_WS_NONPIPE_EXTRA 9'h001

// Wait states on a cache miss that hits the open page in pipelined mode.
`define WSC_PAGE_HIT_WS 9'h001

// Wait states on a write to the coprocessor reset port.
`define WSC_COPROC_RESET_WS 9'h082

// The coprocessor reset port address.
`define WSC_COPROC_RESET_PORT 16'h00f1

// Double-frequency clock phases that make up one wait state.
`define WSC_PHASES_PER_WS 10'h002

`endif

// ---- pkg/wsc_pkg.sv ----
// Types shared by the wait-state controller and its bench.
package wsc_pkg;

  // Kind of bus cycle announced at its start.
  typedef enum logic [2:0] {
    WSC_CYC_CACHE_HIT,
    WSC_CYC_PAGE_HIT,
    WSC_CYC_LOCAL_IO,
    WSC_CYC_CHANNEL,
    WSC_CYC_HALT,
    WSC_CYC_COPROC
  } wsc_kind_type;

  // Operating frequency selected by the straps.
  typedef enum logic [1:0] {
    WSC_FREQ_16,
    WSC_FREQ_20,
    WSC_FREQ_25,
    WSC_FREQ_33
  } wsc_freq_type;

  // Description of one bus cycle, valid with the start strobe.
  typedef struct packed {
    wsc_kind_type kind;
    logic         after_pipelined;
    logic         write;
    logic [15:0]  io_addr;
  } wsc_cycle_type;

  // Ready answer towards the processor, with its output enable.
  typedef struct packed {
    logic ready_n;
    logic ready_oe;
  } wsc_ready_type;

endpackage : wsc_pkg

// ---- testbench/wsc_chk.sv ----
// Port checker for the wait-state controller.
module wsc_chk
  import wsc_pkg::*;
(
  // Clock, reset and requests.
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          cycle_start_i,
  input wire wsc_cycle_type cycle_i,
  input wire logic          channel_ready_return_n_i,
  input wire logic          test_n_i,
  // Answers.
  input wire logic          sys_ready_out_n_o,
  input wire logic          sys_ready_oe_o,
  input wire logic          bus_size16_oe_o,
  input wire logic          cycle_busy_o,
  input wire wsc_freq_type  freq_sel_o
);
  logic [9:0] cnt_reg;
  logic [9:0] exp_reg;
  logic [2:0] age_reg;
  logic       go;
  int         io_ws [4] = '{3, 3, 5, 7};

  // An accepted start; starts while busy are ignored.
  assign go = cycle_start_i && !cycle_busy_o;

  // Edges since the accepted start, counted from one so that zero stays free to
  // mark a channel cycle, and the figure the ready must arrive at.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 10'h000;
      exp_reg <= 10'h000;
    end else if (go) begin
      cnt_reg <= 10'h001;
      case (cycle_i.kind)
        WSC_CYC_HALT:     exp_reg <= 10'h001;
        WSC_CYC_PAGE_HIT: exp_reg <= 10'h003;
        WSC_CYC_LOCAL_IO: exp_reg <= (cycle_i.write && cycle_i.io_addr == 16'h00f1) ? 10'h105
                                     : 10'(2 * (io_ws[freq_sel_o] + !cycle_i.after_pipelined) + 1);
        default:          exp_reg <= 10'h000; // Channel cycles have no fixed figure.
      endcase
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end

  // Edges since reset, saturating once the strap capture is surely over.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      age_reg <= 3'h0;
    end else if (age_reg != 3'h5) begin
      age_reg <= age_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_WAIT: assert property (!sys_ready_out_n_o && exp_reg != 0 |-> cnt_reg == exp_reg)
    else $error("ready at wrong count");
  AST_LATE: assert property (cycle_busy_o && exp_reg != 0 |-> cnt_reg <= exp_reg)
    else $error("ready overdue");
  AST_HALT: assert property (go && cycle_i.kind == WSC_CYC_HALT |=> !sys_ready_out_n_o)
    else $error("halt not answered at once");
  AST_PAGE: assert property (go && cycle_i.kind == WSC_CYC_PAGE_HIT |=> sys_ready_out_n_o [*2] ##1 !sys_ready_out_n_o)
    else $error("page hit not one wait state");
  AST_QUIET: assert property (go && (cycle_i.kind == WSC_CYC_CACHE_HIT || cycle_i.kind == WSC_CYC_COPROC)
    |=> (!cycle_busy_o && !sys_ready_oe_o) [*2])
    else $error("ready driven on a silent cycle");
  AST_CHAN: assert property (!sys_ready_out_n_o && exp_reg == 0 |-> $past(channel_ready_return_n_i, 3) == 1'b0)
    else $error("channel cycle ended without return");
  AST_PULSE: assert property (!sys_ready_out_n_o |-> sys_ready_oe_o ##1 (sys_ready_out_n_o && !cycle_busy_o))
    else $error("ready pulse wrong");
  AST_TEST: assert property (!test_n_i [*3] |-> !sys_ready_oe_o && !bus_size16_oe_o)
    else $error("outputs driven in test mode");
  AST_FREQ: assert property (age_reg == 3'h5 |-> $stable(freq_sel_o))
    else $error("frequency changed after capture");

  // Main scenarios.
  cover property (go && cycle_i.kind == WSC_CYC_LOCAL_IO && cycle_i.io_addr == 16'h00f1);
  cover property (go && cycle_i.kind == WSC_CYC_CHANNEL);
  cover property (!test_n_i [*3]);
endmodule : wsc_chk

bind wsc_wait_state_controller wsc_chk u_wsc_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cycle_start_i(cycle_start_i), .cycle_i(cycle_i), .test_n_i(test_n_i),
  .channel_ready_return_n_i(channel_ready_return_n_i), .sys_ready_out_n_o(sys_ready_out_n_o),
  .sys_ready_oe_o(sys_ready_oe_o), .bus_size16_oe_o(bus_size16_oe_o),
  .cycle_busy_o(cycle_busy_o), .freq_sel_o(freq_sel_o));

// ---- testbench/wsc_chan_partner.sv ----
// Channel-side model that returns ready and data size after a delay.
module wsc_chan_partner (
  // Bench control and design status.
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic busy_i,
  input  int        dly_i,
  // Returns to the controller.
  output logic      ret_n_o,
  output logic      s16_n_o,
  output logic      s32_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // The return is held back for the delay, then held low until the cycle ends.
  initial begin
    ret_n_o = 1'b1;
    s16_n_o = 1'b1;
    s32_n_o = 1'b1;
    forever begin
      @(posedge go_i);
      repeat (dly_i) @(negedge clk_i);
      ret_n_o = 1'b0;
      s16_n_o = dly_i[0];
      s32_n_o = dly_i[1];
      @(negedge busy_i);
      @(negedge clk_i);
      ret_n_o = 1'b1;
      s16_n_o = 1'b1;
      s32_n_o = 1'b1;
    end
  end
endmodule : wsc_chan_partner

// ---- testbench/test_wait_state_controller.sv ----
// Self-checking bench for the wait-state controller.
module test_wait_state_controller
  import wsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk_i = 1'b0, rst_i = 1'b1, start = 1'b0, test_n = 1'b1;
  logic          hi = 1'b0, lo = 1'b0, go = 1'b0;
  logic          rdy_n, oe, s16n, s16oe, busy, ret_n, s16r, s32r;
  wsc_cycle_type cyc = 21'h000000;
  wsc_freq_type  fsel;
  int            fail_count = 0, num_checks = 0, dly = 1, e;
  int            io_ws [4] = '{3, 3, 5, 7};
  integer        seed = 32'hd4658a41;
  logic [15:0]   a;

  wsc_wait_state_controller u_wsc_wait_state_controller (.clk_i(clk_i), .rst_i(rst_i),
    .cycle_start_i(start), .cycle_i(cyc), .channel_ready_return_n_i(ret_n),
    .size16_return_n_i(s16r), .size32_return_n_i(s32r), .freq_strap_hi_i(hi),
    .freq_strap_lo_i(lo), .test_n_i(test_n), .sys_ready_out_n_o(rdy_n), .sys_ready_oe_o(oe),
    .bus_size16_n_o(s16n), .bus_size16_oe_o(s16oe), .cycle_busy_o(busy), .freq_sel_o(fsel));
  wsc_chan_partner u_wsc_chan_partner (.clk_i(clk_i), .go_i(go), .busy_i(busy), .dly_i(dly),
    .ret_n_o(ret_n), .s16_n_o(s16r), .s32_n_o(s32r));

  // Clock and a watchdog sized well above the expected run.
  initial forever #20 clk_i = ~clk_i;
  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end

  task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Straps stay steady through the whole reset so they are caught cleanly;
  // the capture lands on the third edge after release, so wait past it.
  task automatic do_reset(input logic h, input logic l);
    hi = h;
    lo = l;
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : do_reset

  // One start pulse, then edges are counted until ready goes low or the limit runs out.
  task automatic run_cycle(input wsc_kind_type k, input logic ap, input logic [15:0] ad,
                           input logic wr, input int lim, output int n);
    cyc = {k, ap, wr, ad};
    start = 1'b1;
    go = (k == WSC_CYC_CHANNEL);
    @(negedge clk_i);
    start = 1'b0;
    go = 1'b0;
    n = 0;
    while (rdy_n !== 1'b0 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (n < lim) begin
      check_val(oe, 1'b1);
      if (k == WSC_CYC_CHANNEL) check_val(ret_n, 1'b0);
      if (k == WSC_CYC_CHANNEL) check_val(s16n, !(s16r == 1'b0 && s32r == 1'b1));
      @(negedge clk_i);
      check_val(busy, 1'b0);
    end
    @(negedge clk_i);
  endtask : run_cycle

  // Every frequency strap, then every cycle kind against the reference figures.
  initial begin
    @(negedge clk_i);
    for (int f = 0; f < 4; f++) begin
      do_reset(f[1], f[0] ^ f[1]);
      check_val(fsel, f);
      a = 16'($random(seed));
      if (a == 16'h00f1) a = 16'h0000;
      run_cycle(WSC_CYC_LOCAL_IO, 1'b1, a, 1'($random(seed)), 300, e);
      check_val(e, 2 * io_ws[f]);
      run_cycle(WSC_CYC_LOCAL_IO, 1'b0, a, 1'b1, 300, e);
      check_val(e, 2 * (io_ws[f] + 1));
      run_cycle(WSC_CYC_PAGE_HIT, 1'b1, a, 1'b0, 300, e);
      check_val(e, 2);
      run_cycle(WSC_CYC_HALT, 1'b0, a, 1'b0, 300, e);
      check_val(e, 0);
      run_cycle(WSC_CYC_CACHE_HIT, 1'b1, a, 1'b0, 8, e);
      check_val(e, 8);
      run_cycle(WSC_CYC_COPROC, 1'b1, a, 1'b1, 8, e); // The coprocessor ends it itself.
      check_val(e, 8);
      run_cycle(WSC_CYC_LOCAL_IO, 1'b1, 16'h00f1, 1'b1, 300, e);
      check_val(e, 260);
      dly = 1 + ($random(seed) & 7);
      run_cycle(WSC_CYC_CHANNEL, 1'b1, a, 1'b0, 300, e);
      check_val(e < 300, 1'b1);
      $display("test freq %0d done", f);
    end
    // Test pin low in the middle of a long cycle releases the outputs after its synchroniser.
    cyc = {WSC_CYC_LOCAL_IO, 1'b1, 1'b1, 16'h00f1};
    start = 1'b1;
    @(negedge clk_i);
    start = 1'b0;
    test_n = 1'b0;
    repeat (3) @(negedge clk_i);
    check_val(busy, 1'b1);
    check_val(oe, 1'b0);
    check_val(s16oe, 1'b0);
    test_n = 1'b1;
    repeat (3) @(negedge clk_i);
    check_val(oe, 1'b1);
    check_val(s16oe, 1'b1);
    repeat (260) @(negedge clk_i);
    check_val(busy, 1'b0);
    $display("test release done");
    stop_test();
  end
endmodule : test_wait_state_controller
